/* File: hw/rssc_defines.svh */
// Constants for the strapped remote serial port: offsets, fields, timing.
// Assumes inclusion by bare name from the design file; the package does not include it.
//
// What this block does
// [R1] Four rate straps, MSB first, index sixteen ascending rates from 50 to 19200.
// [R2] Every strap reads open as one and grounded as zero.
// [R3] Unit address is two BCD digits; first digit low, second digit high.
// [R4] One strap enables parity, another picks even or odd parity.
// [R5] Jumpers pick two single-ended or one differential line; straps act alike.
// [R6] In remote operation the front-panel inputs are ignored.
// [R7] Straps sampled once after reset, held; only own-address messages accepted.
`ifndef RSSC_DEFINES_SVH
`define RSSC_DEFINES_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define RSSC_OFF_CTRL 4'h0
`define RSSC_OFF_STATUS 4'h4
`define RSSC_OFF_RXDATA 4'h8
`define RSSC_OFF_TXDATA 4'hC
`define RSSC_CTRL_REMOTE 0
`define RSSC_RX_VALID_BIT 8
`define RSSC_RESP_OKAY 2'h0
`define RSSC_RESP_SLVERR 2'h2
`define RSSC_CTRL_RESET 1'h0

// ----------------------------------------
// Timing: clock rate and the rate table in tenths of a baud
// ----------------------------------------
`define RSSC_CLK_HZ 50000000
`define RSSC_DIV(hz, r10) (((hz) * 10 + (r10) / 2) / (r10) - 1)
`define RSSC_R0 500
`define RSSC_R1 750
`define RSSC_R2 1100
`define RSSC_R3 1345
`define RSSC_R4 1500
`define RSSC_R5 3000
`define RSSC_R6 6000
`define RSSC_R7 12000
`define RSSC_R8 18000
`define RSSC_R9 20000
`define RSSC_R10 24000
`define RSSC_R11 36000
`define RSSC_R12 48000
`define RSSC_R13 72000
`define RSSC_R14 96000
`define RSSC_R15 192000

`endif

/* File: hw/rssc_pkg.sv */
// Types shared by the strapped remote serial port.
// Assumes the defines header is compiled alongside.
package rssc_pkg;
  // Bit-level sequencer states, used by both directions
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } rssc_ser_t;
  // Line variant jumpers
  typedef enum logic [1:0] {
    VAR_SE_A = 2'b00,
    VAR_SE_B = 2'b01,
    VAR_DIFF = 2'b10
  } rssc_var_t;
endpackage : rssc_pkg

/* File: hw/rssc_top.sv */
// Strapped remote serial port with AXI4-Lite registers and a receive FIFO.
// Assumes all inputs synchronous to aclk; straps static while running.
`timescale 1ns/100ps
`include "rssc_defines.svh"

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module rssc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = ce & in_valid & in_ready;
  wire pop = ce & out_valid & out_ready;
  // Extra pointer bit tells full from empty
  assign in_ready = (wr_q[AW] == rd_q[AW]) | (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  // Storage has no reset, only the pointers do
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : rssc_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module rssc_top #(
  parameter int CLK_HZ = `RSSC_CLK_HZ,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rate_sel_bit3,
  input wire logic rate_sel_bit2,
  input wire logic rate_sel_bit1,
  input wire logic rate_sel_bit0,
  input wire logic [3:0] address_low_digit,
  input wire logic [3:0] address_high_digit,
  input wire logic parity_sel_n,
  input wire logic parity_odd_sel,
  input wire logic [1:0] line_variant,
  input wire logic panel_valid,
  input wire logic [7:0] panel_data,
  output logic panel_ready,
  input wire logic ser_rx_a,
  input wire logic ser_rx_b,
  output logic ser_tx_a,
  output logic ser_tx_b
);
  // Bit period minus one for a rate index
  function automatic logic [19:0] rssc_div(input logic [3:0] idx);
    case (idx)
      4'h0: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R0));
      4'h1: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R1));
      4'h2: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R2));
      4'h3: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R3));
      4'h4: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R4));
      4'h5: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R5));
      4'h6: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R6));
      4'h7: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R7));
      4'h8: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R8));
      4'h9: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R9));
      4'hA: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R10));
      4'hB: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R11));
      4'hC: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R12));
      4'hD: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R13));
      4'hE: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R14));
      default: rssc_div = 20'(`RSSC_DIV(CLK_HZ, `RSSC_R15));
    endcase
  endfunction : rssc_div

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic taken_q;
  logic [3:0] rate_q;
  logic [7:0] addr_q;
  logic par_en_q;
  logic par_odd_q;
  logic [1:0] var_q;
  logic [19:0] div_q;
  // Caught once after release, then frozen for the whole run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 1'b0;
      rate_q <= 4'h0;
      addr_q <= 8'h00;
      par_en_q <= 1'b0;
      par_odd_q <= 1'b0;
      var_q <= 2'h0;
      div_q <= 20'h00000;
    end else if (ce && !taken_q) begin // see [R7]
      taken_q <= 1'b1;
      rate_q <= {rate_sel_bit3, rate_sel_bit2, rate_sel_bit1, rate_sel_bit0}; // see [R1] [R2]
      div_q <= rssc_div({rate_sel_bit3, rate_sel_bit2, rate_sel_bit1, rate_sel_bit0}); // see [R1]
      addr_q <= {address_high_digit, address_low_digit}; // see [R3]
      par_en_q <= ~parity_sel_n; // see [R4] [R2]
      par_odd_q <= parity_odd_sel; // see [R4]
      var_q <= line_variant; // see [R5]
    end
  end

  // Differential takes B (mark positive); strap logic is the same either way
  wire diff = var_q == rssc_pkg::VAR_DIFF; // see [R5]
  wire rx_in = diff ? ser_rx_b : ser_rx_a;

  // ----------------------------------------
  // Receive sequencer
  // ----------------------------------------
  rssc_pkg::rssc_ser_t rx_st_q;
  logic [19:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_perr_q;
  logic rx_done_q;
  wire rx_tick = rx_cnt_q == 20'h00000;
  wire rx_par = (^rx_sh_q) ^ par_odd_q;
  // Start is checked again mid-bit so glitches do not start a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= rssc_pkg::ST_IDLE;
      rx_cnt_q <= 20'h00000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_perr_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else if (ce) begin
      rx_done_q <= 1'b0;
      rx_cnt_q <= rx_tick ? div_q : rx_cnt_q - 1'b1;
      case (rx_st_q)
        rssc_pkg::ST_IDLE: begin
          rx_cnt_q <= div_q >> 1;
          rx_perr_q <= 1'b0;
          if (taken_q && !rx_in) rx_st_q <= rssc_pkg::ST_START;
        end
        rssc_pkg::ST_START: begin
          if (rx_tick) rx_st_q <= rx_in ? rssc_pkg::ST_IDLE : rssc_pkg::ST_DATA;
          rx_bit_q <= 3'h0;
        end
        rssc_pkg::ST_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= {rx_in, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == 3'h7) rx_st_q <= par_en_q ? rssc_pkg::ST_PAR : rssc_pkg::ST_STOP; // see [R4]
          end
        end
        rssc_pkg::ST_PAR: begin
          if (rx_tick) begin
            rx_perr_q <= rx_in != rx_par; // see [R4]
            rx_st_q <= rssc_pkg::ST_STOP;
          end
        end
        rssc_pkg::ST_STOP: begin
          if (rx_tick) begin
            rx_done_q <= rx_in & ~rx_perr_q;
            rx_st_q <= rssc_pkg::ST_IDLE;
          end
        end
        default: rx_st_q <= rssc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Message filter and source select
  // ----------------------------------------
  logic ctrl_remote_q;
  logic ctrl_remote_d;
  logic want_cmd_q;
  logic match_q;
  logic hold_vld_q;
  logic [7:0] hold_q;
  logic panel_ready_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire ser_load = ctrl_remote_q & rx_done_q & want_cmd_q & match_q & ~hold_vld_q; // see [R7]
  wire panel_load = panel_valid & panel_ready_q; // see [R6]
  wire hold_vld_d = (hold_vld_q & ~fifo_in_ready) | ser_load | panel_load;
  // Frames are an address byte followed by one command byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      want_cmd_q <= 1'b0;
      match_q <= 1'b0;
      hold_vld_q <= 1'b0;
      hold_q <= 8'h00;
      panel_ready_q <= 1'b0;
    end else if (ce) begin
      if (rx_done_q) begin
        want_cmd_q <= ~want_cmd_q;
        if (!want_cmd_q) match_q <= rx_sh_q == addr_q; // see [R7] [R3]
      end
      hold_vld_q <= hold_vld_d;
      if (ser_load) hold_q <= rx_sh_q;
      if (panel_load) hold_q <= panel_data;
      // Panel shut out as soon as remote is set
      panel_ready_q <= ~ctrl_remote_d & ~hold_vld_d & taken_q; // see [R6]
    end
  end

  logic rx_pop;
  rssc_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(hold_vld_q),
    .in_ready(fifo_in_ready),
    .in_data(hold_q),
    .out_valid(fifo_out_valid),
    .out_ready(rx_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  rssc_pkg::rssc_ser_t tx_st_q;
  logic [19:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_pbit_q;
  logic tx_line_q;
  logic tx_go;
  logic [7:0] wb_q; // Write byte held by the bus side; wdata may move once taken
  wire tx_tick = tx_cnt_q == 20'h00000;
  wire tx_busy = tx_st_q != rssc_pkg::ST_IDLE;
  // Writes while busy are dropped; status shows busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= rssc_pkg::ST_IDLE;
      tx_cnt_q <= 20'h00000;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_pbit_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (ce) begin
      tx_cnt_q <= tx_tick ? div_q : tx_cnt_q - 1'b1;
      case (tx_st_q)
        rssc_pkg::ST_IDLE: begin
          tx_line_q <= 1'b1;
          tx_cnt_q <= div_q;
          tx_bit_q <= 3'h0;
          if (tx_go) begin
            tx_sh_q <= wb_q;
            tx_pbit_q <= (^wb_q) ^ par_odd_q; // see [R4]
            tx_line_q <= 1'b0;
            tx_st_q <= rssc_pkg::ST_START;
          end
        end
        rssc_pkg::ST_START: begin
          if (tx_tick) begin
            tx_line_q <= tx_sh_q[0];
            tx_st_q <= rssc_pkg::ST_DATA;
          end
        end
        rssc_pkg::ST_DATA: begin
          if (tx_tick) begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_bit_q <= tx_bit_q + 1'b1;
            tx_line_q <= tx_sh_q[1];
            if (tx_bit_q == 3'h7) begin
              tx_line_q <= par_en_q ? tx_pbit_q : 1'b1; // see [R4]
              tx_st_q <= par_en_q ? rssc_pkg::ST_PAR : rssc_pkg::ST_STOP;
            end
          end
        end
        rssc_pkg::ST_PAR: begin
          if (tx_tick) begin
            tx_line_q <= 1'b1;
            tx_st_q <= rssc_pkg::ST_STOP;
          end
        end
        rssc_pkg::ST_STOP: begin
          if (tx_tick) tx_st_q <= rssc_pkg::ST_IDLE;
        end
        default: tx_st_q <= rssc_pkg::ST_IDLE;
      endcase
    end
  end

  // Line drive per jumper variant, A is mark negative when differential
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_tx_a <= 1'b1;
      ser_tx_b <= 1'b0;
    end else if (ce) begin
      ser_tx_a <= diff ? ~tx_line_q : tx_line_q; // see [R5]
      ser_tx_b <= diff & tx_line_q;
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_q;
  logic wb_en_q;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid;
  wire bvalid_d = wr_fire | (bvalid & ~bready);
  wire aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
  wire w_have_d = (w_have_q | w_take) & ~wr_fire;
  wire wr_ok = (aw_q == `RSSC_OFF_CTRL) | (aw_q == `RSSC_OFF_STATUS) | (aw_q == `RSSC_OFF_TXDATA)
    | (aw_q == `RSSC_OFF_RXDATA);
  wire ar_take = arvalid & arready;
  wire rvalid_d = ar_take | (rvalid & ~rready);
  wire ar_ok = (araddr == `RSSC_OFF_CTRL) | (araddr == `RSSC_OFF_STATUS) | (araddr == `RSSC_OFF_TXDATA)
    | (araddr == `RSSC_OFF_RXDATA);
  assign ctrl_remote_d = (wr_fire & wb_en_q & (aw_q == `RSSC_OFF_CTRL)) ?
    wb_q[`RSSC_CTRL_REMOTE] : ctrl_remote_q;
  assign tx_go = wr_fire & wb_en_q & (aw_q == `RSSC_OFF_TXDATA) & ~tx_busy & taken_q;
  assign rx_pop = ar_take & (araddr == `RSSC_OFF_RXDATA);
  wire [31:0] status = {14'h0, tx_busy, fifo_out_valid, var_q, par_odd_q, par_en_q, rate_q, addr_q};
  wire [31:0] rd_mux = (araddr == `RSSC_OFF_CTRL) ? {31'h0, ctrl_remote_q} :
    (araddr == `RSSC_OFF_STATUS) ? status :
    (araddr == `RSSC_OFF_RXDATA) ? {23'h0, fifo_out_valid, fifo_out_data} : 32'h00000000;

  // Write side: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 4'h0;
      wb_q <= 8'h00;
      wb_en_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RSSC_RESP_OKAY;
      ctrl_remote_q <= `RSSC_CTRL_RESET;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_take) aw_q <= {awaddr[3:2], 2'b00};
      if (w_take) wb_q <= wdata[7:0];
      if (w_take) wb_en_q <= wstrb[0];
      awready <= ~aw_have_d & ~bvalid_d;
      wready <= ~w_have_d & ~bvalid_d;
      bvalid <= bvalid_d;
      if (wr_fire) bresp <= wr_ok ? `RSSC_RESP_OKAY : `RSSC_RESP_SLVERR;
      ctrl_remote_q <= ctrl_remote_d; // see [R6]
    end
  end

  // Read side: one cycle to data; RXDATA read pops the FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RSSC_RESP_OKAY;
      panel_ready <= 1'b0;
    end else if (ce) begin
      arready <= ~rvalid_d;
      rvalid <= rvalid_d;
      if (ar_take) rdata <= rd_mux;
      if (ar_take) rresp <= ar_ok ? `RSSC_RESP_OKAY : `RSSC_RESP_SLVERR;
      panel_ready <= ~ctrl_remote_d & ~hold_vld_d & taken_q;
    end
  end
endmodule : rssc_top

/* File: verif/rssc_assertions.sv */
// Checker for the strapped serial port: bus answers, strap fields, line pins.
// Assumes straps are stable while reset is held and on the first edge after.
`timescale 1ns/100ps
module rssc_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rate_sel_bit3,
  input wire logic rate_sel_bit2,
  input wire logic rate_sel_bit1,
  input wire logic rate_sel_bit0,
  input wire logic [3:0] address_low_digit,
  input wire logic [3:0] address_high_digit,
  input wire logic parity_sel_n,
  input wire logic parity_odd_sel,
  input wire logic [1:0] line_variant,
  input wire logic ser_tx_a,
  input wire logic ser_tx_b
);
  logic [3:0] ra_q;
  logic [15:0] cap_q;
  logic st_rd;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Strap image taken in reset, since the block must not track later moves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= {line_variant, parity_odd_sel, ~parity_sel_n, rate_sel_bit3, rate_sel_bit2,
        rate_sel_bit1, rate_sel_bit0, address_high_digit, address_low_digit};
    end
    if (arvalid && arready) begin
      ra_q <= araddr;
    end
  end
  assign st_rd = rvalid && ra_q == 4'h4;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && ser_tx_a)
    else $error("outputs not idle after reset");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before taken");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer changed before taken");
  rd_lat_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  ar_block_a: assert property (rvalid |-> !arready) else $error("second read taken");
  rate_field_a: assert property (st_rd |-> rdata[11:8] == cap_q[11:8])
    else $error("rate index wrong");
  addr_field_a: assert property (st_rd |-> rdata[7:0] == cap_q[7:0])
    else $error("unit address wrong");
  par_field_a: assert property (st_rd |-> rdata[13:12] == cap_q[13:12])
    else $error("parity setting wrong");
  se_pin_a: assert property (cap_q[15:14] != 2'h2 |-> ser_tx_b == 1'b0)
    else $error("spare pin driven in single ended");
  diff_pin_a: assert property (cap_q[15:14] == 2'h2 |-> ser_tx_a != ser_tx_b)
    else $error("pair not complementary");
  c_status: cover property (st_rd && rready);
  c_rxdata: cover property (rvalid && ra_q == 4'h8 && rdata[8]);
  c_diff: cover property (cap_q[15:14] == 2'h2 && !ser_tx_b);
endmodule : rssc_assertions

/* File: verif/rssc_remote_model.sv */
// Remote controller: sends framed bytes to the receive pins.
// Assumes the bench calls send; BIT is the bit period in clocks.
`timescale 1ns/100ps
module rssc_remote_model #(
  parameter int BIT = 10
) (
  input wire logic aclk,
  output logic line_a,
  output logic line_b
);
  // Both pins carry line level; mark is high, so idle rests high
  initial begin
    line_a = 1'b1;
    line_b = 1'b1;
  end
  // Start, eight bits LSB first, optional parity, one stop
  task automatic send(input logic [7:0] b, input logic pe, input logic odd, input logic bad);
    logic [10:0] f;
    f = pe ? {1'b1, ^b ^ odd ^ bad, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < (pe ? 11 : 10); i++) begin
      @(posedge aclk);
      line_a <= f[i];
      line_b <= f[i];
      repeat (BIT - 1) @(posedge aclk);
    end
  endtask : send
endmodule : rssc_remote_model

/* File: verif/rssc_top_tb.sv */
// Bench for the strapped remote serial port.
// Assumes CLK_HZ set so the fastest rate gives ten clocks a bit.
`timescale 1ns/100ps
module rssc_top_tb;
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, panel_valid = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, address_low_digit, address_high_digit;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [7:0] panel_data = 8'h0;
  logic rate_sel_bit3, rate_sel_bit2, rate_sel_bit1, rate_sel_bit0, parity_sel_n, parity_odd_sel;
  logic [1:0] line_variant, bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, panel_ready, ser_rx_a, ser_rx_b, ser_tx_a, ser_tx_b;
  int n_fail = 0;
  int checked = 0;
  wire txl = line_variant[1] ? ser_tx_b : ser_tx_a;
  rssc_top #(.CLK_HZ(192000), .FIFO_DEPTH(32)) u_rssc_top (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rate_sel_bit3, .rate_sel_bit2, .rate_sel_bit1, .rate_sel_bit0,
    .address_low_digit, .address_high_digit, .parity_sel_n, .parity_odd_sel, .line_variant, .panel_valid,
    .panel_data, .panel_ready, .ser_rx_a, .ser_rx_b, .ser_tx_a, .ser_tx_b);
  rssc_remote_model #(.BIT(10)) u_rssc_remote_model (.aclk, .line_a(ser_rx_a), .line_b(ser_rx_b));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Straps as {variant, odd, parity_n, rate[3:0], high, low}
  task automatic straps(input logic [15:0] s);
    {line_variant, parity_odd_sel, parity_sel_n, rate_sel_bit3, rate_sel_bit2, rate_sel_bit1,
      rate_sel_bit0, address_high_digit, address_low_digit} <= s;
  endtask : straps
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  // Answer taken one edge late on purpose, to exercise the hold
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    rv = rdata;
    rs = rresp;
  endtask : rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_status(input logic [15:0] exp);
    rd(4'h4);
    cmp("status", {16'h0, exp}, rv);
    cmp("status resp", 32'h0, {30'h0, rs});
  endtask : t_status
  task automatic t_regs;
    wr(4'h4, 32'hFFFFFFFF);
    cmp("ro write resp", 32'h0, {30'h0, rs});
    rd(4'hC);
    cmp("txdata read", 32'h0, rv);
    rd(4'h0);
    cmp("ctrl reset", 32'h0, rv);
  endtask : t_regs
  // Byte 01: start bit is the first low span, bit 0 the first high one
  task automatic t_tx(input int exp);
    int i;
    int n;
    int h;
    fork
      wr(4'hC, 32'h1);
      begin
        i = 0;
        while (txl !== 1'b0 && i < 100) begin @(posedge aclk); i++; end
        n = 0;
        while (txl === 1'b0 && n < 5000) begin @(posedge aclk); n++; end
        h = 0;
        while (txl === 1'b1 && h < 5000) begin @(posedge aclk); h++; end
      end
    join
    cmp("bit period", exp, n);
    cmp("first data bit", exp, h);
  endtask : t_tx
  // Panel fills the FIFO with nobody draining, then reads empty it
  task automatic t_fill;
    int n;
    int m;
    n = 0;
    panel_valid <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (panel_ready) begin n++; panel_data <= 8'(n); end
    end
    panel_valid <= 1'b0;
    cmp("fill refused", 32'h1, {31'h0, n >= 32 && n <= 33});
    for (m = 0; m < 60; m++) begin
      rd(4'h8);
      if (rv[8] !== 1'b1) break;
      cmp("fifo order", 32'(m), {24'h0, rv[7:0]});
    end
    cmp("drain count", n, m);
  endtask : t_fill
  task automatic t_rx;
    int n;
    wr(4'h0, 32'h1);
    n = 0;
    panel_valid <= 1'b1;
    repeat (8) begin @(posedge aclk); n += panel_ready; end
    panel_valid <= 1'b0;
    cmp("panel in remote", 32'h0, n);
    u_rssc_remote_model.send(8'h37, 1'b1, 1'b1, 1'b0);
    u_rssc_remote_model.send(8'h5A, 1'b1, 1'b1, 1'b0);
    repeat (30) @(posedge aclk);
    rd(4'h8);
    cmp("own message", 32'h15A, rv);
    u_rssc_remote_model.send(8'h73, 1'b1, 1'b1, 1'b0);
    u_rssc_remote_model.send(8'h5A, 1'b1, 1'b1, 1'b0);
    repeat (30) @(posedge aclk);
    rd(4'h8);
    cmp("other address", 32'h0, {31'h0, rv[8]});
    u_rssc_remote_model.send(8'h37, 1'b1, 1'b1, 1'b0);
    u_rssc_remote_model.send(8'h66, 1'b1, 1'b1, 1'b1);
    repeat (30) @(posedge aclk);
    rd(4'h8);
    cmp("bad parity", 32'h0, {31'h0, rv[8]});
  endtask : t_rx
  // Watchdog well beyond the slow start and first data bits plus all traffic
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
  initial begin
    straps(16'h2F37);
    do_reset();
    t_status(16'h3F37);
    t_regs();
    t_tx(10);
    t_fill();
    t_rx();
    straps(16'h9092);
    t_status(16'h3F37);
    do_reset();
    t_status(16'h8092);
    t_tx(3840);
    test_done();
  end
endmodule : rssc_top_tb
bind rssc_top rssc_assertions u_rssc_assertions (.aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .bresp, .bvalid, .bready, .rate_sel_bit3, .rate_sel_bit2, .rate_sel_bit1, .rate_sel_bit0,
  .address_low_digit, .address_high_digit, .parity_sel_n, .parity_odd_sel, .line_variant, .ser_tx_a, .ser_tx_b);
